// File: design/frrs_pkg.sv
// Purpose: constants for the floppy rate control and result status block
// Assumes: 32-bit AHB-Lite register access, one word per register
package frrs_pkg;
    // =====================================================================
    // register byte addresses
    // =====================================================================
    localparam logic [11:0] FRRS_RATE_CONTROL_OFS = 12'h3f7; // printed offset
    // the printed offset is a register index, so its word sits at four times it
    localparam logic [11:0] FRRS_RATE_CONTROL_ADR = {FRRS_RATE_CONTROL_OFS[9:0], 2'b00};
    localparam logic [11:0] FRRS_INPUT_ADR        = 12'h000; // readback of flag
    localparam logic [11:0] FRRS_CONFIG_ADR       = 12'h004; // mode bits
    localparam logic [11:0] FRRS_RESULT_ADR       = 12'h008; // result bytes
    localparam logic [11:0] FRRS_EVENT_ADR        = 12'h00c; // sticky events
    localparam logic [11:0] FRRS_MASK_ADR         = 12'h010; // event mask
    // =====================================================================
    // field positions and reset values
    // =====================================================================
    localparam int          FRRS_PRECOMP_BIT   = 2;
    localparam int          FRRS_IDENT_BIT     = 1;
    localparam int          FRRS_VARIANT_BIT   = 0;
    localparam logic [1:0]  FRRS_RATE_RST      = 2'h2;
    localparam logic [1:0]  FRRS_CONFIG_RST    = 2'h2;
    localparam logic [1:0]  FRRS_RATE_1M       = 2'h3;
    localparam logic [1:0]  FRRS_RATE_500K     = 2'h0;
    localparam logic [1:0]  FRRS_EVENTS_RST    = 2'h0;
    // termination codes
    localparam logic [1:0]  FRRS_TERM_NORMAL   = 2'h0;
    localparam logic [1:0]  FRRS_TERM_ABNORMAL = 2'h1;
    localparam logic [1:0]  FRRS_TERM_INVALID  = 2'h2;
    localparam logic [1:0]  FRRS_TERM_POLLING  = 2'h3;
    // register set modes
    typedef enum logic [2:0] {
        FRRS_MODE_COMPAT = 3'b001,
        FRRS_MODE_SECOND = 3'b010,
        FRRS_MODE_THIRD  = 3'b100
    } frrs_mode_t;
endpackage : frrs_pkg

// File: design/frrs_top.sv
// Purpose: rate control register, density select and result status encoding
// Assumes: single AHB-Lite master, all inputs synchronous to hclk
// Notes: event bit 0 = result ready, bit 1 = illegal FM rate code
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module frrs_top import frrs_pkg::*; (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        clk_en,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             irq,
    input  wire logic        soft_reset,
    input  wire logic        result_load,
    input  wire logic [1:0]  termination_code,
    input  wire logic        seek_done,
    input  wire logic        recal_no_track_zero,
    input  wire logic        seek_past_track_zero,
    input  wire logic        head_address,
    input  wire logic [1:0]  drive_number,
    input  wire logic        past_final_sector,
    input  wire logic        data_cmd_no_tc,
    input  wire logic        crc_fault,
    input  wire logic        service_late,
    input  wire logic        sector_not_found,
    input  wire logic        id_unreadable,
    input  wire logic        sequence_wrong,
    input  wire logic        write_blocked,
    input  wire logic        no_id_mark,
    input  wire logic        no_data_mark,
    output logic             density_select_out,
    output logic [1:0]       rate_code,
    output logic             fm_rate_illegal
);
    // =====================================================================
    // bus address phase capture
    // =====================================================================
    logic        wr_pend_r;      // write data phase pending
    logic        rd_pend_r;      // read data phase pending
    logic [11:0] addr_r;         // latched word address
    wire         take = hsel & hready & htrans[1] & clk_en;
    wire  [11:0] word_adr = {haddr[11:2], 2'b00};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r    <= 12'h000;
        end else if (clk_en) begin
            wr_pend_r <= take & hwrite;
            rd_pend_r <= take & ~hwrite;
            if (take) begin
                addr_r <= word_adr;
            end
        end
    end

    wire wr_rate   = wr_pend_r & (addr_r == FRRS_RATE_CONTROL_ADR);
    wire wr_config = wr_pend_r & (addr_r == FRRS_CONFIG_ADR);
    wire wr_mask   = wr_pend_r & (addr_r == FRRS_MASK_ADR);
    // the rate register owns a whole word; its byte is the low lane
    wire [7:0] rate_byte = hwdata[7:0];

    // =====================================================================
    // rate control and mode configuration
    // =====================================================================
    logic [1:0] rate_r;          // rate code, kept over soft reset
    logic       precomp_r;       // skip-precomp flag, no function
    logic [1:0] config_r;        // ident and variant_select_bit
    logic       dens_r;          // density select output flop

    // mode decode: ident high is the compatible set
    function automatic frrs_mode_t mode_of(input logic [1:0] c);
        if (c[FRRS_IDENT_BIT]) begin
            return FRRS_MODE_COMPAT;
        end else if (c[FRRS_VARIANT_BIT]) begin
            return FRRS_MODE_SECOND;
        end
        return FRRS_MODE_THIRD;
    endfunction : mode_of

    wire frrs_mode_t mode = mode_of(config_r);
    wire third_mode = (mode == FRRS_MODE_THIRD);
    // fast rates give low density when ident is 0, inverted at 1
    wire fast_rate  = (rate_r == FRRS_RATE_1M) | (rate_r == FRRS_RATE_500K);
    wire dens_nxt   = config_r[FRRS_IDENT_BIT] ? fast_rate : ~fast_rate;

    // upper bits are ignored except bit 2, the precomp flag in the third set; software is expected to keep them 0
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rate_r    <= FRRS_RATE_RST;
            precomp_r <= 1'b0;
            config_r  <= FRRS_CONFIG_RST;
            dens_r    <= 1'b1;
        end else if (clk_en) begin
            if (wr_rate) begin
                rate_r <= rate_byte[1:0];
                if (third_mode) begin
                    precomp_r <= rate_byte[FRRS_PRECOMP_BIT];
                end
            end
            if (wr_config) begin
                config_r <= hwdata[1:0];
            end
            // soft reset does not touch density or flag
            dens_r <= dens_nxt;
        end
    end

    // =====================================================================
    // result status bytes
    // =====================================================================
    logic [7:0] st0_r;           // first result status byte
    logic [7:0] st1_r;           // second result status byte
    wire  [7:0] st0_nxt = {termination_code,
                           seek_done,
                           recal_no_track_zero | seek_past_track_zero,
                           1'b0, head_address, drive_number};
    wire  [7:0] st1_nxt = {past_final_sector | data_cmd_no_tc,
                           1'b0,
                           crc_fault,
                           service_late,
                           1'b0,
                           sector_not_found | id_unreadable | sequence_wrong,
                           write_blocked,
                           no_id_mark | no_data_mark};

    // soft reset clears result bytes; the core restarts idle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st0_r <= 8'h00;
            st1_r <= 8'h00;
        end else if (clk_en) begin
            if (soft_reset) begin
                st0_r <= 8'h00;
                st1_r <= 8'h00;
            end else if (result_load) begin
                st0_r <= st0_nxt;
                st1_r <= st1_nxt;
            end
        end
    end

    // =====================================================================
    // events, mask and interrupt
    // =====================================================================
    logic [1:0] ev_r;            // sticky: result ready, illegal fm code
    logic [1:0] mask_r;          // 1 enables the event onto irq
    logic       irq_r;
    wire  fm_bad   = ~config_r[FRRS_VARIANT_BIT] & (rate_r == FRRS_RATE_1M);
    wire  [1:0] ev_set = {fm_bad, result_load & ~soft_reset};
    wire  rd_ev    = rd_pend_r & (addr_r == FRRS_EVENT_ADR);
    // set beats the clear of a read in the same cycle
    wire  [1:0] ev_nxt = (rd_ev ? 2'b00 : ev_r) | ev_set;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ev_r   <= FRRS_EVENTS_RST;
            mask_r <= 2'b00;
            irq_r  <= 1'b0;
        end else if (clk_en) begin
            ev_r   <= ev_nxt;
            irq_r  <= |(ev_nxt & (wr_mask ? hwdata[1:0] : mask_r));
            if (wr_mask) begin
                mask_r <= hwdata[1:0];
            end
        end
    end

    // =====================================================================
    // read data, registered in the address phase
    // =====================================================================
    logic [31:0] rdata_r;
    logic [31:0] rsel;
    always_comb begin
        rsel = 32'h0000_0000;
        case (word_adr)
            FRRS_INPUT_ADR:  rsel = {29'h0, precomp_r & third_mode, rate_r};
            FRRS_CONFIG_ADR: rsel = {30'h0, config_r};
            FRRS_RESULT_ADR: rsel = {16'h0, st1_r, st0_r};
            FRRS_EVENT_ADR:  rsel = {30'h0, ev_r};
            FRRS_MASK_ADR:   rsel = {30'h0, mask_r};
            default:         rsel = 32'h0000_0000; // rate reg is write-only
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_r <= 32'h0000_0000;
        end else if (clk_en && take && !hwrite) begin
            rdata_r <= rsel;
        end
    end

    // =====================================================================
    // outputs, all from flops except hreadyout and hresp, which are tied constants
    // =====================================================================
    logic [1:0] rate_out_r;
    logic       fm_ill_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rate_out_r <= FRRS_RATE_RST;
            fm_ill_r   <= 1'b0;
        end else if (clk_en) begin
            rate_out_r <= rate_r;
            fm_ill_r   <= fm_bad;
        end
    end

    assign hrdata             = rdata_r;
    assign hreadyout          = 1'b1;
    assign hresp              = 1'b0;
    assign irq                = irq_r;
    assign density_select_out = dens_r;
    assign rate_code          = rate_out_r;
    assign fm_rate_illegal    = fm_ill_r;
endmodule : frrs_top

// File: tb/floppy_rate_and_result_status_tb.sv
// Purpose: self-checking bench for rate control and result status
// Assumes: zero wait state bus
// Notes: status causes packed in sv, bit 15 passes the drive model
`timescale 1ns/100ps
module floppy_rate_and_result_status_tb import frrs_pkg::*; ();
    logic        hclk, hresetn, hsel, hwrite, soft_reset, result_load, wb;
    logic        clk_en;   // run enable, dropped once to prove the freeze
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0]  htrans, rate_code;
    logic [17:0] sv;   // one bit per status cause
    logic [15:0] e;    // expected result word
    logic        hreadyout, hresp, irq, density_select_out, fm_rate_illegal;
    int          error_cnt = 0;
    int          checked = 0;
    frrs_top u_frrs_top (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .irq,
        .soft_reset, .result_load, .termination_code(sv[1:0]), .seek_done(sv[2]),
        .recal_no_track_zero(sv[3]), .seek_past_track_zero(sv[4]), .head_address(sv[5]),
        .drive_number(sv[7:6]), .past_final_sector(sv[8]), .data_cmd_no_tc(sv[9]),
        .crc_fault(sv[10]), .service_late(sv[11]), .sector_not_found(sv[12]),
        .id_unreadable(sv[13]), .sequence_wrong(sv[14]), .write_blocked(wb),
        .no_id_mark(sv[16]), .no_data_mark(sv[17]), .density_select_out, .rate_code,
        .fm_rate_illegal);
    frrs_drive_model u_frrs_drive_model (.tab_in(sv[15]), .density_select_out,
        .write_blocked(wb), .high_density());
    // =====================================================
    // clock, compare and bus tasks
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    task chk(input string n, input logic [31:0] s, input logic [31:0] x);
        checked++;
        if (s !== x) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, x, s);
        end
    endtask : chk
    // single transfer, read data left in r; waits on hready, never on a count
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : bus
    // result load pulse, then time for event and irq to settle
    task load(input logic [17:0] v);
        @(posedge hclk);
        sv          <= v;
        result_load <= 1'b1;
        @(posedge hclk);
        result_load <= 1'b0;
        repeat (3) @(posedge hclk);
        #1;
    endtask : load
    task finish_test;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finish_test
    // =====================================================
    // scenarios
    task t_rate;
        for (int m = 0; m < 2; m++) begin
            for (int c = 0; c < 4; c++) begin
                bus(1'b1, FRRS_CONFIG_ADR, m * 2 + 1); // second or compatible set
                bus(1'b1, FRRS_RATE_CONTROL_ADR, c);
                @(posedge hclk);
                #1;
                chk("rate_code", rate_code, c);
                chk("density", density_select_out, (c == 1 || c == 2) ^ m);
                bus(1'b0, FRRS_INPUT_ADR, 0);
                chk("input rate", r[1:0], c);
                bus(1'b0, FRRS_RATE_CONTROL_ADR, 0);
                chk("write only", r, 0);
            end
        end
    endtask : t_rate
    // third set: flag and density must ride through a soft reset
    task t_third;
        bus(1'b1, FRRS_CONFIG_ADR, 0);
        bus(1'b1, FRRS_RATE_CONTROL_ADR, 32'h0000_0007);
        @(posedge hclk);
        soft_reset <= 1'b1;
        @(posedge hclk);
        soft_reset <= 1'b0;
        #1;
        chk("fm illegal", fm_rate_illegal, 1);
        bus(1'b0, FRRS_INPUT_ADR, 0);
        chk("flag", r[2:0], 3'h7);
        chk("density kept", density_select_out, 0);
        bus(1'b1, FRRS_RATE_CONTROL_ADR, 32'h0000_0002);
        bus(1'b0, FRRS_EVENT_ADR, 0);
        chk("fm event", r[1], 1);
        bus(1'b1, FRRS_CONFIG_ADR, 2);
    endtask : t_third
    // with the enable low a rate write must leave no trace
    task t_freeze;
        clk_en <= 1'b0;
        bus(1'b1, FRRS_RATE_CONTROL_ADR, 1);
        repeat (2) @(posedge hclk);
        clk_en <= 1'b1;
        bus(1'b0, FRRS_INPUT_ADR, 0);
        chk("frozen rate", r[1:0], 2'h2);
    endtask : t_freeze
    // walk one cause at a time, then all together
    task t_result;
        bus(1'b1, FRRS_MASK_ADR, 1);
        for (int b = 0; b < 19; b++) begin
            load(b < 18 ? 18'h1 << b : 18'h3ffff);
            e = {sv[8] | sv[9], 1'b0, sv[10], sv[11], 1'b0, sv[12] | sv[13] | sv[14], sv[15],
                 sv[16] | sv[17], sv[1:0], sv[2], sv[3] | sv[4], 1'b0, sv[5], sv[7:6]};
            chk("irq set", irq, 1);
            bus(1'b0, FRRS_EVENT_ADR, 0);
            chk("ready event", r[0], 1);
            bus(1'b0, FRRS_RESULT_ADR, 0);
            chk("s0", r[7:0], e[7:0]);
            chk("s1 hi", r[15:12], e[15:12]);
            chk("s1 lo", r[11:8], e[11:8]);
            chk("irq cleared", irq, 0);
        end
        bus(1'b1, FRRS_MASK_ADR, 0);
        load(18'h0);
        chk("irq masked", irq, 0);
    endtask : t_result
    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, soft_reset, result_load} = 4'h0;
        clk_en = 1'b1;
        {haddr, hwdata} = 64'h0;
        {htrans, sv} = 20'h0;
        repeat (5) @(posedge hclk);
        chk("density reset", density_select_out, 1);
        hresetn <= 1'b1;
        bus(1'b0, FRRS_INPUT_ADR, 0);
        chk("rate reset", r[2:0], 3'h2);
        bus(1'b0, 32'h0000_0020, 0);
        chk("unmapped", r, 0);
        t_rate;
        t_third;
        t_freeze;
        t_result;
        finish_test;
    end
    // watchdog: the tests need a few hundred cycles
    initial begin
        #100000;
        error_cnt++;
        finish_test;
    end
endmodule : floppy_rate_and_result_status_tb

// File: tb/frrs_drive_model.sv
// Purpose: drive side model: write protect tab and density sense
// Assumes: tab level set by the bench
// Notes: no cable delay modelled
`timescale 1ns/100ps
module frrs_drive_model (
    input  wire logic tab_in,
    input  wire logic density_select_out,
    output logic      write_blocked,
    output logic      high_density
);
    // tab switch feeds the controller straight through
    assign write_blocked = tab_in;
    // drive reads the density line inverted: high density when the line is low
    assign high_density  = !density_select_out;
endmodule : frrs_drive_model

// File: tb/frrs_sva.sv
// Purpose: port checks for rate control and result status
// Assumes: zero wait state slave
// Notes: bound to frrs_top below
`timescale 1ns/100ps
module frrs_sva import frrs_pkg::*; (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        clk_en,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [1:0]  rate_code,
    input wire logic        fm_rate_illegal
);
    // =====================================================
    // data phase tracking
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire       take     = hsel & htrans[1] & clk_en; // hready is always high here
    wire       hit_rate = haddr[11:0] == FRRS_RATE_CONTROL_ADR;
    wire       hit_res  = haddr[11:0] == FRRS_RESULT_ADR;
    logic [2:0] ph_q;   // data phase of rate write, rate read, result read
    // remember which access owns the current data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_q <= 3'h0;
        end else begin
            ph_q <= {take & hwrite & hit_rate, take & !hwrite & hit_rate, take & !hwrite & hit_res};
        end
    end
    // =====================================================
    // checks
    a_resp_okay: assert property (hresp == 1'b0) else $error("bad hresp");
    a_zero_wait: assert property (hreadyout == 1'b1) else $error("wait state");
    // register loads at the data phase edge, the output copy one edge later
    a_rate_load: assert property (ph_q[2] |-> ##2 rate_code == $past(hwdata[1:0], 2))
        else $error("rate not loaded");
    a_rate_still: assert property ($changed(rate_code) |-> $past(ph_q[2]) || $past(ph_q[2], 2))
        else $error("rate moved alone");
    a_rate_hidden: assert property (ph_q[1] |-> hrdata == 32'h0) else $error("rate readable");
    a_head_gap: assert property (ph_q[0] |-> !hrdata[3]) else $error("bit 3 set");
    a_unused_zero: assert property (ph_q[0] |-> !hrdata[14] && !hrdata[11])
        else $error("unused bit set");
    a_fm_code: assert property ($rose(fm_rate_illegal) |-> rate_code == FRRS_RATE_1M)
        else $error("fm flag wrong");
    c_res_read: cover property (ph_q[0]);
    c_rate_wr: cover property (ph_q[2]);
    c_fm_flag: cover property ($rose(fm_rate_illegal));
endmodule : frrs_sva

bind frrs_top frrs_sva u_frrs_sva (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite,
    .hwdata, .hrdata, .hreadyout, .hresp, .rate_code, .fm_rate_illegal);
